// ### src/pci_parity_error_response.sv
// PCI/PCI-X parity error response logic with AXI4-Lite register access
`timescale 1ns/1ps
module pci_parity_error_response (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output      logic                     s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output      logic                     s_axi_wready,
  // AXI4-Lite write response
  output      logic [1:0]               s_axi_bresp,
  output      logic                     s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output      logic                     s_axi_arready,
  output      logic [31:0]              s_axi_rdata,
  output      logic [1:0]               s_axi_rresp,
  output      logic                     s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Bus mode
  input  wire logic                     pcix_mode,
  // Address or attribute parity error from the target decoder
  input  wire logic                     addr_par_err,
  input  wire pci_perr_pkg::txn_kind_t  addr_err_kind,
  // Outbound read data phase and split response termination
  input  wire logic                     rd_data_phase,
  input  wire logic                     rd_par_err,
  input  wire logic                     split_resp_term,
  input  wire logic                     split_par_err,
  // Outbound write PERR# sampling and MSI completion
  input  wire logic                     wr_perr_sample,
  input  wire logic                     wr_is_msi,
  input  wire logic                     msi_done,
  // PERR# pin, two-way
  input  wire logic                     perr_n_i,
  output      logic                     perr_n_o,
  output      logic                     perr_n_oe_n,
  // SERR# pin, open drain
  output      logic                     serr_n_o,
  output      logic                     serr_n_oe_n,
  // Bus control
  output      logic                     target_abort,
  output      logic                     force_idle,
  // Interrupt
  output      logic                     irq
);

  import pci_perr_pkg::*;
  // Configuration, status and interrupt registers
  logic [31:0] unit_command_reg, next_unit_command_reg;
  logic [31:0] pcix_command_reg, next_pcix_command_reg;
  logic [31:0] unit_status_reg,  next_unit_status_reg;
  logic [31:0] dma_status_reg,   next_dma_status_reg;
  logic [31:0] irq_mask_reg,     next_irq_mask_reg;

  // AXI slave state
  logic        aw_held, next_aw_held;
  logic        w_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [1:0]  rresp, next_rresp;
  logic [31:0] rdata, next_rdata;

  // Error pipelines and pin drivers
  logic [PERR_DLY_PCIX-2:0] pend_short, next_pend_short;
  logic [PERR_DLY_PCIX-2:0] pend_long, next_pend_long;
  logic        perr_drv, next_perr_drv;
  logic        serr_drv, next_serr_drv;
  logic        ta_q, next_ta_q;
  logic        idle_q, next_idle_q;
  msi_state_t  msi_state, next_msi_state;

  // Decoded enables
  logic        per_en, serr_en, dpere, serr_pcix_ok;
  logic        do_write, wr_hit, wr_nonmsi, msi_fire, perr_fire;
  logic        ap_abort, ap_serr, rd_err, sp_err;
  logic [31:0] wmask, usr_set, usr_clr;
  logic        dma_err_set;

  assign per_en       = unit_command_reg[CMD_PER_BIT];
  assign serr_en      = unit_command_reg[CMD_SERR_EN_BIT];
  assign dpere        = pcix_command_reg[PCIX_DPERE_BIT];
  assign serr_pcix_ok = pcix_mode & serr_en & ~dpere;

  // Address parity: abort only reads and non-memory writes, never posted ones
  assign ap_abort = addr_par_err & per_en &
                    (addr_err_kind inside {KIND_CFG_RD, KIND_CFG_WR, KIND_IO_RD,
                                           KIND_IO_WR, KIND_MEM_RD});
  assign ap_serr  = addr_par_err & per_en & serr_en;

  // Initiator-side read errors; inbound read errors have no input at all
  assign rd_err = rd_data_phase & rd_par_err;
  assign sp_err = split_resp_term & split_par_err & pcix_mode;

  // Target reported PERR# during one of our writes
  assign wr_hit    = wr_perr_sample & ~perr_n_i;
  assign wr_nonmsi = wr_hit & ~wr_is_msi;
  assign msi_fire  = (msi_state == MSI_PEND) & msi_done;

  // PERR# goes out from the pipeline stage that matches the mode
  assign perr_fire = pend_short[PERR_DLY_CONV-2] | pend_long[PERR_DLY_PCIX-2];

  // Byte lane mask for register writes
  assign wmask    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign do_write = aw_held & w_held & ~bvalid;

  // Hardware set and software clear masks for the unit status register
  always_comb begin
    usr_set = 32'h0000_0000;
    usr_set[USR_TA_BIT]   = ap_abort;
    usr_set[USR_DPE_BIT]  = addr_par_err | rd_err | sp_err;
    usr_set[USR_MPE_BIT]  = perr_fire | (wr_nonmsi & per_en) | msi_fire;
    usr_set[USR_SERR_BIT] = next_serr_drv;
    usr_clr = 32'h0000_0000;
    if (do_write && aw_addr == ADDR_UNIT_STAT) begin
      usr_clr = w_data & wmask & USR_MASK;
    end
  end

  // DMA error from read, split or reported write parity
  assign dma_err_set = rd_err | sp_err | wr_nonmsi;

  // Next values of the registers; a hardware set beats a same-cycle clear
  always_comb begin
    next_unit_command_reg = unit_command_reg;
    next_pcix_command_reg = pcix_command_reg;
    next_irq_mask_reg     = irq_mask_reg;
    next_dma_status_reg   = dma_status_reg;
    if (do_write) begin
      if (aw_addr == ADDR_UNIT_CMD) begin
        next_unit_command_reg = (unit_command_reg & ~(wmask & CMD_MASK)) |
                                (w_data & wmask & CMD_MASK);
      end else if (aw_addr == ADDR_PCIX_CMD) begin
        next_pcix_command_reg = (pcix_command_reg & ~(wmask & PCIX_MASK)) |
                                (w_data & wmask & PCIX_MASK);
      end else if (aw_addr == ADDR_IRQ_MASK) begin
        next_irq_mask_reg = (irq_mask_reg & ~(wmask & USR_MASK)) |
                            (w_data & wmask & USR_MASK);
      end else if (aw_addr == ADDR_DMA_STAT) begin
        if (w_strb[0]) begin
          next_dma_status_reg[DMA_ACTIVE_BIT] = w_data[DMA_ACTIVE_BIT];
          if (w_data[DMA_ERR_BIT]) begin
            next_dma_status_reg[DMA_ERR_BIT] = 1'b0;
          end
        end
      end
    end
    if (dma_err_set) begin
      next_dma_status_reg[DMA_ERR_BIT]    = 1'b1;
      next_dma_status_reg[DMA_ACTIVE_BIT] = 1'b0;
    end
    next_unit_status_reg = (unit_status_reg & ~usr_clr) | usr_set;
  end

  // Register the configuration and status state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_command_reg <= CMD_RESET;
      pcix_command_reg <= PCIX_RESET;
      unit_status_reg  <= USR_RESET;
      dma_status_reg   <= DMA_RESET;
      irq_mask_reg     <= MASK_RESET;
    end else begin
      unit_command_reg <= next_unit_command_reg;
      pcix_command_reg <= next_pcix_command_reg;
      unit_status_reg  <= next_unit_status_reg;
      dma_status_reg   <= next_dma_status_reg;
      irq_mask_reg     <= next_irq_mask_reg;
    end
  end

  // Error pipelines, MSI follow-up and pin drivers
  always_comb begin
    next_pend_short = {pend_short[PERR_DLY_PCIX-3:0], rd_err & per_en & ~pcix_mode};
    next_pend_long  = {pend_long[PERR_DLY_PCIX-3:0],
                       ((rd_err & pcix_mode) | sp_err) & per_en};
    next_perr_drv   = perr_fire;
    // SERR# sources are mutually independent; any one drives the pin
    next_serr_drv   = ap_serr | (perr_fire & serr_pcix_ok) |
                      (wr_nonmsi & per_en & serr_pcix_ok) | (msi_fire & serr_en);
    next_ta_q       = ap_abort;
    next_idle_q     = addr_par_err | rd_err | sp_err | wr_hit;
    next_msi_state  = msi_state;
    case (msi_state)
      MSI_IDLE: begin
        // Only remembered when parity response is enabled
        if (wr_hit && wr_is_msi && per_en) begin
          next_msi_state = MSI_PEND;
        end
      end
      MSI_PEND: begin
        if (msi_done) begin
          next_msi_state = MSI_IDLE;
        end
      end
      default: next_msi_state = MSI_IDLE;
    endcase
  end

  // Register the error pipelines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_short <= '0;
      pend_long  <= '0;
      perr_drv   <= 1'b0;
      serr_drv   <= 1'b0;
      ta_q       <= 1'b0;
      idle_q     <= 1'b0;
      msi_state  <= MSI_IDLE;
    end else begin
      pend_short <= next_pend_short;
      pend_long  <= next_pend_long;
      perr_drv   <= next_perr_drv;
      serr_drv   <= next_serr_drv;
      ta_q       <= next_ta_q;
      idle_q     <= next_idle_q;
      msi_state  <= next_msi_state;
    end
  end

  // Pins are driven low only while asserted, otherwise released
  assign perr_n_o     = 1'b0;
  assign perr_n_oe_n  = ~perr_drv;
  assign serr_n_o     = 1'b0;
  assign serr_n_oe_n  = ~serr_drv;
  assign target_abort = ta_q;
  assign force_idle   = idle_q;
  assign irq          = |(unit_status_reg & irq_mask_reg);

  // AXI slave: address and data taken in either order, one write at a time
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      if (aw_addr == ADDR_UNIT_CMD || aw_addr == ADDR_UNIT_STAT ||
          aw_addr == ADDR_PCIX_CMD || aw_addr == ADDR_DMA_STAT ||
          aw_addr == ADDR_IRQ_MASK) begin
        next_bresp = RESP_OKAY;
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Read side answers one cycle after the address is taken
  always_comb begin
    next_rvalid = rvalid;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      if (s_axi_araddr == ADDR_UNIT_CMD) begin
        next_rdata = unit_command_reg;
      end else if (s_axi_araddr == ADDR_UNIT_STAT) begin
        next_rdata = unit_status_reg;
      end else if (s_axi_araddr == ADDR_PCIX_CMD) begin
        next_rdata = pcix_command_reg;
      end else if (s_axi_araddr == ADDR_DMA_STAT) begin
        next_rdata = dma_status_reg;
      end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
        next_rdata = irq_mask_reg;
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_SLVERR;
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Register the bus slave state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h0000_0000;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
    end
  end

  // Ready while the slot is free and no response is owed
  assign s_axi_awready = ~aw_held & ~bvalid;
  assign s_axi_wready  = ~w_held & ~bvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = ~rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;

  // Checks on the error response timing and status effects
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_perr_conv_delay: assert property (
    rd_data_phase && rd_par_err && per_en && !pcix_mode |-> ##2 !perr_n_oe_n)
    else $error("PERR# not asserted two clocks after conventional read error");
  a_perr_pcix_delay: assert property (
    split_resp_term && split_par_err && pcix_mode && per_en |-> ##3 !perr_n_oe_n)
    else $error("PERR# not asserted three clocks after split response error");
  a_perr_disabled: assert property (
    !per_en [*3] |-> perr_n_oe_n)
    else $error("PERR# asserted with parity response disabled");
  a_perr_sets_mpe: assert property (
    !perr_n_oe_n |-> $past(unit_status_reg[USR_MPE_BIT]) || unit_status_reg[USR_MPE_BIT])
    else $error("Master parity error not set along with PERR#");
  a_ta_bit11: assert property (
    addr_par_err && per_en && addr_err_kind == KIND_CFG_RD |->
      ##1 target_abort && unit_status_reg[USR_TA_BIT])
    else $error("Target abort or its status bit missing");
  a_no_abort_memwr: assert property (
    addr_par_err && addr_err_kind == KIND_MEM_WR |-> ##1 !target_abort)
    else $error("Memory write was target-aborted");
  a_dpe_always: assert property (
    addr_par_err |-> ##1 unit_status_reg[USR_DPE_BIT])
    else $error("Detected parity error not set on address parity error");
  a_serr_flag: assert property (
    !serr_n_oe_n |-> unit_status_reg[USR_SERR_BIT])
    else $error("SERR# asserted without its status flag");
  a_dma_err_read: assert property (
    rd_data_phase && rd_par_err |->
      ##1 dma_status_reg[DMA_ERR_BIT] && !dma_status_reg[DMA_ACTIVE_BIT])
    else $error("DMA status not updated on read parity error");
  a_msi_wait: assert property (
    msi_state == MSI_PEND && !msi_done |-> ##1 serr_n_oe_n)
    else $error("SERR# raised before MSI write finished");

  c_perr_conv: cover property (rd_data_phase && rd_par_err && per_en ##2 !perr_n_oe_n);
  c_target_abort: cover property (target_abort);
  c_msi_serr: cover property (msi_state == MSI_PEND ##1 msi_done ##1 !serr_n_oe_n);
  c_irq: cover property (irq);

endmodule

// ### src/pci_perr_pkg.sv
// Constants, register map and types for the PCI parity error response block
package pci_perr_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_UNIT_CMD  = 8'h00;
  localparam logic [7:0] ADDR_UNIT_STAT = 8'h04;
  localparam logic [7:0] ADDR_PCIX_CMD  = 8'h08;
  localparam logic [7:0] ADDR_DMA_STAT  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h10;

  // Command register fields
  localparam int CMD_PER_BIT     = 6;
  localparam int CMD_SERR_EN_BIT = 8;
  localparam int PCIX_DPERE_BIT  = 0;

  // Unit status register fields
  localparam int USR_MPE_BIT  = 8;
  localparam int USR_TA_BIT   = 11;
  localparam int USR_SERR_BIT = 14;
  localparam int USR_DPE_BIT  = 15;

  // DMA status register fields
  localparam int DMA_ACTIVE_BIT = 0;
  localparam int DMA_ERR_BIT    = 1;

  // Reset values and writable masks
  localparam logic [31:0] CMD_RESET   = 32'h0000_0000;
  localparam logic [31:0] CMD_MASK    = 32'h0000_0140;
  localparam logic [31:0] PCIX_RESET  = 32'h0000_0000;
  localparam logic [31:0] PCIX_MASK   = 32'h0000_0001;
  localparam logic [31:0] USR_RESET   = 32'h0000_0000;
  localparam logic [31:0] USR_MASK    = 32'h0000_C900;
  localparam logic [31:0] DMA_RESET   = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;

  // PERR# delay after the erroneous phase, in bus clocks
  localparam int PERR_DLY_CONV = 2;
  localparam int PERR_DLY_PCIX = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Kind of transaction that suffered an address or attribute parity error
  typedef enum logic [2:0] {
    KIND_CFG_RD    = 3'h0,
    KIND_CFG_WR    = 3'h1,
    KIND_IO_RD     = 3'h2,
    KIND_IO_WR     = 3'h3,
    KIND_MEM_RD    = 3'h4,
    KIND_MEM_WR    = 3'h5,
    KIND_SPLIT_CPL = 3'h6,
    KIND_OTHER     = 3'h7
  } txn_kind_t;

  // MSI error follow-up state, one-hot
  typedef enum logic [1:0] {
    MSI_IDLE = 2'b01,
    MSI_PEND = 2'b10
  } msi_state_t;

endpackage

// ### bench/pci_far_agent.sv
// Far-side PCI agent: resolves the PERR# wire and flags write data errors
`timescale 1ns/1ps
module pci_far_agent (
  // Device side of PERR#
  input  wire logic perr_n_o,
  input  wire logic perr_n_oe_n,
  // Bench command: report a write data parity error this cycle
  input  wire logic report_err,
  // Resolved wire level
  output      logic perr_line
);
  // Pull-up holds the line high unless someone drives it; the target pulls it low
  always_comb begin
    perr_line = 1'b1;
    if (report_err) perr_line = 1'b0;
    if (!perr_n_oe_n) perr_line = perr_line & perr_n_o;
  end
endmodule

// ### bench/pci_parity_error_response_test.sv
// Self-checking bench for the parity error response block
`timescale 1ns/1ps
module pci_parity_error_response_test import pci_perr_pkg::*;;
  localparam logic [31:0] MPE  = 32'h0000_0100;
  localparam logic [31:0] TA   = 32'h0000_0800;
  localparam logic [31:0] SERR = 32'h0000_4000;
  localparam logic [31:0] DPE  = 32'h0000_8000;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, agent_err;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        pcix_mode, addr_par_err, rd_data_phase, rd_par_err, split_resp_term;
  logic        split_par_err, wr_perr_sample, wr_is_msi, msi_done;
  txn_kind_t   addr_err_kind;
  logic        awready, wready, bvalid, arready, rvalid, perr_line, perr_n_o, perr_n_oe_n;
  logic        serr_n_o, serr_n_oe_n, target_abort, force_idle, irq;
  logic [1:0]  bresp, rresp, last_resp;
  int          miscompares = 0, n_compared = 0, cycles = 0;

  // Device under test and the far-side agent sharing PERR#
  pci_parity_error_response i_pci_parity_error_response (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pcix_mode(pcix_mode), .addr_par_err(addr_par_err), .addr_err_kind(addr_err_kind),
    .rd_data_phase(rd_data_phase), .rd_par_err(rd_par_err),
    .split_resp_term(split_resp_term), .split_par_err(split_par_err),
    .wr_perr_sample(wr_perr_sample), .wr_is_msi(wr_is_msi), .msi_done(msi_done),
    .perr_n_i(perr_line), .perr_n_o(perr_n_o), .perr_n_oe_n(perr_n_oe_n),
    .serr_n_o(serr_n_o), .serr_n_oe_n(serr_n_oe_n), .target_abort(target_abort),
    .force_idle(force_idle), .irq(irq));
  pci_far_agent i_pci_far_agent (
    .perr_n_o(perr_n_o), .perr_n_oe_n(perr_n_oe_n), .report_err(agent_err),
    .perr_line(perr_line));

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic test_done;
    begin
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
      n_compared++;
      if (got !== exp) begin
        miscompares++;
        $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    begin
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      while (pa || pw) begin
        @(negedge aclk);
        ta = pa && awready;
        tw = pw && wready;
        @(posedge aclk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
        pa = pa && !ta;
        pw = pw && !tw;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      last_resp = bresp;
      @(posedge aclk);
      bready <= 1'b0;
    end
  endtask

  // Read one word and compare it
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    begin
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      {got, last_resp} = {rdata, rresp};
      @(posedge aclk);
      rready <= 1'b0;
      cmp(got, exp, "read data");
    end
  endtask

  // Enables, bus mode, and DMA marked active
  task automatic cfg(input logic per, input logic serr, input logic dpere, input logic px);
    begin
      axi_wr(ADDR_UNIT_CMD, {23'h0, serr, 1'b0, per, 6'h0});
      axi_wr(ADDR_PCIX_CMD, {31'h0, dpere});
      axi_wr(ADDR_DMA_STAT, 32'h0000_0001);
      pcix_mode <= px;
    end
  endtask

  // Check status words, then clear errors and re-arm DMA active
  task automatic after(input logic [31:0] usr, input logic [31:0] dma);
    begin
      axi_rd(ADDR_UNIT_STAT, usr);
      axi_rd(ADDR_DMA_STAT, dma);
      axi_wr(ADDR_UNIT_STAT, 32'hFFFF_FFFF);
      axi_wr(ADDR_DMA_STAT, 32'h0000_0003);
    end
  endtask

  // Pulse {addr, read, split, write, msi_done}; note the cycle PERR#, SERR#, target abort and idle fire
  task automatic ev(input logic [4:0] p, input int ep, input int es, input int et,
                    input int ef);
    int pk = -1, sk = -1, tk = -1, fk = -1;
    begin
      @(posedge aclk);
      {addr_par_err, rd_data_phase, rd_par_err, split_resp_term} <= {p[4], p[3], p[3], p[2]};
      {split_par_err, wr_perr_sample, agent_err, msi_done} <= {p[2], p[1], p[1], p[0]};
      for (int k = 0; k < 6; k++) begin
        @(negedge aclk);
        if (pk < 0 && perr_n_oe_n === 1'b0) pk = k;
        if (sk < 0 && serr_n_oe_n === 1'b0 && serr_n_o === 1'b0) sk = k;
        if (tk < 0 && target_abort === 1'b1) tk = k;
        if (fk < 0 && force_idle === 1'b1) fk = k;
        @(posedge aclk);
        {addr_par_err, rd_data_phase, rd_par_err, split_resp_term} <= 4'h0;
        {split_par_err, wr_perr_sample, agent_err, msi_done} <= 4'h0;
      end
      cmp(pk, ep, "PERR# cycle");
      cmp(sk, es, "SERR# cycle");
      cmp(tk, et, "target abort cycle");
      if (ef != -2) cmp(fk, ef, "idle cycle");
    end
  endtask

  task automatic irq_chk(input logic exp);
    begin
      @(negedge aclk);
      cmp(32'(irq), 32'(exp), "irq level");
    end
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      $display("MISMATCH at %0t: timeout", $time);
      test_done;
    end
  end

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, agent_err, pcix_mode} = '0;
    {addr_par_err, rd_data_phase, rd_par_err, split_resp_term, split_par_err} = '0;
    {wr_perr_sample, wr_is_msi, msi_done, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    addr_err_kind = KIND_CFG_RD;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 6; a++) axi_rd(8'(a * 4), 32'h0000_0000);
    cmp(32'(last_resp), 32'(RESP_SLVERR), "unmapped read");
    axi_wr(8'h14, 32'hFFFF_FFFF);
    cmp(32'(last_resp), 32'(RESP_SLVERR), "unmapped write");
    cfg(1, 1, 0, 0);
    for (int k = 0; k < 8; k++) begin
      addr_err_kind <= txn_kind_t'(k);
      ev(5'b10000, -1, 1, (k < 5) ? 1 : -1, 1);
      after(DPE | SERR | ((k < 5) ? TA : 32'h0000_0000), 1);
    end
    cfg(0, 1, 0, 0);
    axi_wr(ADDR_IRQ_MASK, DPE);
    ev(5'b10000, -1, -1, -1, 1);
    axi_wr(ADDR_UNIT_STAT, 32'h0000_0000);
    axi_rd(ADDR_UNIT_STAT, DPE);
    irq_chk(1'b1);
    axi_wr(ADDR_IRQ_MASK, 32'h0000_0000);
    irq_chk(1'b0);
    axi_wr(ADDR_IRQ_MASK, DPE);
    after(DPE, 1);
    irq_chk(1'b0);
    cfg(1, 1, 0, 0);
    ev(5'b01000, PERR_DLY_CONV, -1, -1, 1);
    after(MPE | DPE, 2);
    cfg(1, 1, 0, 1);
    ev(5'b01000, PERR_DLY_PCIX, PERR_DLY_PCIX, -1, 1);
    after(MPE | DPE | SERR, 2);
    cfg(1, 1, 1, 1);
    ev(5'b01000, PERR_DLY_PCIX, -1, -1, 1);
    after(MPE | DPE, 2);
    cfg(0, 1, 0, 0);
    ev(5'b01000, -1, -1, -1, 1);
    after(DPE, 2);
    cfg(1, 1, 0, 1);
    ev(5'b00100, PERR_DLY_PCIX, PERR_DLY_PCIX, -1, 1);
    after(MPE | DPE | SERR, 2);
    cfg(1, 1, 1, 1);
    ev(5'b00100, PERR_DLY_PCIX, -1, -1, 1);
    after(MPE | DPE, 2);
    cfg(1, 1, 0, 1);
    ev(5'b00010, -1, 1, -1, 1);
    after(MPE | SERR, 2);
    cfg(1, 1, 0, 0);
    ev(5'b00010, -1, -1, -1, 1);
    after(MPE, 2);
    cfg(0, 1, 0, 1);
    ev(5'b00010, -1, -1, -1, 1);
    after(32'h0000_0000, 2);
    cfg(1, 1, 1, 0);
    wr_is_msi <= 1'b1;
    ev(5'b00010, -1, -1, -1, 1);
    axi_rd(ADDR_UNIT_STAT, 32'h0000_0000);
    ev(5'b00001, -1, 1, -1, -1);
    after(MPE | SERR, 1);
    test_done;
  end
endmodule
